// ### hw/ecd_pkg.sv
package ecd_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int NUM_EDGE = 4;

    // ********************************
    // Division ratio choices
    // ********************************
    typedef enum logic [1:0] {
        ECD_RATIO_2_0,
        ECD_RATIO_3_5,
        ECD_RATIO_4_0
    } ecd_ratio_t;

    // Half periods of the input per counter cycle: one divided period, two for 3.5
    localparam logic [3:0] HALF_EDGES_2_0 = 4'h4;
    localparam logic [3:0] HALF_EDGES_3_5 = 4'he;
    localparam logic [3:0] HALF_EDGES_4_0 = 4'h8;

    // Toggle points of the 3.5 pattern, in half periods
    localparam logic [3:0] TOGGLE_3_5_A = 4'h0;
    localparam logic [3:0] TOGGLE_3_5_B = 4'h4;
    localparam logic [3:0] TOGGLE_3_5_C = 4'h7;
    localparam logic [3:0] TOGGLE_3_5_D = 4'hb;

    // ********************************
    // Reset values
    // ********************************
    localparam logic       RESET_LEVEL = 1'b0;
    localparam logic [3:0] RESET_COUNT = 4'h0;

    // ********************************
    // Carriers
    // ********************************
    typedef struct packed {
        logic select;
        logic stop;
        logic div_reset;
        logic word_align_request;
    } ecd_ctrl_t;

    typedef struct packed {
        logic undivided_output;
        logic divided_output;
    } ecd_div_out_t;

endpackage : ecd_pkg

// ### hw/ecd_divider.sv
`timescale 1ns/10ps

module ecd_divider #(
    parameter ecd_pkg::ecd_ratio_t DIV_RATIO = ecd_pkg::ECD_RATIO_2_0,
    parameter bit                  GSR_ENABLE = 1'b0
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire logic                 i_divider_clock_in,
    input  wire logic                 i_div_reset,
    input  wire logic                 i_global_set_reset,
    input  wire logic                 i_word_align_request,
    output ecd_pkg::ecd_div_out_t     o_out
);

    // ********************************
    // Half period counting
    // ********************************
    logic                  prev_r;
    logic                  prev_nxt;
    logic                  align_prev_r;
    logic                  align_prev_nxt;
    logic                  slip_r;
    logic                  slip_nxt;
    logic [3:0]            cnt_r;
    logic [3:0]            cnt_nxt;
    ecd_pkg::ecd_div_out_t out_r;
    ecd_pkg::ecd_div_out_t out_nxt;
    logic                  hold_off;
    logic                  half_edge;

    function automatic logic [3:0] last_count(input ecd_pkg::ecd_ratio_t ratio);
        unique case (ratio)
            ecd_pkg::ECD_RATIO_3_5: last_count = ecd_pkg::HALF_EDGES_3_5 - 4'h1;
            ecd_pkg::ECD_RATIO_4_0: last_count = ecd_pkg::HALF_EDGES_4_0 - 4'h1;
            default:                last_count = ecd_pkg::HALF_EDGES_2_0 - 4'h1;
        endcase
    endfunction : last_count

    function automatic logic toggle_at(input ecd_pkg::ecd_ratio_t ratio, input logic [3:0] c);
        unique case (ratio)
            ecd_pkg::ECD_RATIO_3_5: toggle_at = (c == ecd_pkg::TOGGLE_3_5_A) ||
                                                (c == ecd_pkg::TOGGLE_3_5_B) ||
                                                (c == ecd_pkg::TOGGLE_3_5_C) ||
                                                (c == ecd_pkg::TOGGLE_3_5_D);
            ecd_pkg::ECD_RATIO_4_0: toggle_at = (c[1:0] == 2'h0);
            default:                toggle_at = (c[0] == 1'b0);
        endcase
    endfunction : toggle_at

    always_comb begin
        hold_off       = i_div_reset | (GSR_ENABLE & i_global_set_reset);
        half_edge      = (i_divider_clock_in != prev_r);
        prev_nxt       = i_divider_clock_in;
        align_prev_nxt = i_word_align_request;
        slip_nxt       = slip_r | (i_word_align_request & ~align_prev_r);
        cnt_nxt        = cnt_r;
        out_nxt        = out_r;
        if (hold_off) begin
            cnt_nxt                  = ecd_pkg::RESET_COUNT;
            slip_nxt                 = 1'b0;
            out_nxt.undivided_output = ecd_pkg::RESET_LEVEL;
            out_nxt.divided_output   = ecd_pkg::RESET_LEVEL;
        end else begin
            // Both outputs update in the same cycle from the same edge
            out_nxt.undivided_output = i_divider_clock_in;
            if (half_edge && slip_r) begin
                // Word slip: one half period is swallowed; a fresh request still arms
                slip_nxt = i_word_align_request & ~align_prev_r;
            end else if (half_edge) begin
                if (toggle_at(DIV_RATIO, cnt_r)) begin
                    out_nxt.divided_output = ~out_r.divided_output;
                end
                cnt_nxt = (cnt_r == last_count(DIV_RATIO)) ? ecd_pkg::RESET_COUNT
                                                            : cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            prev_r       <= ecd_pkg::RESET_LEVEL;
            align_prev_r <= 1'b0;
            slip_r       <= 1'b0;
            cnt_r        <= ecd_pkg::RESET_COUNT;
            out_r        <= '0;
        end else begin
            prev_r       <= prev_nxt;
            align_prev_r <= align_prev_nxt;
            slip_r       <= slip_nxt;
            cnt_r        <= cnt_nxt;
            out_r        <= out_nxt;
        end
    end

    assign o_out = out_r;

endmodule : ecd_divider

// ### hw/ecd_edge_clock.sv
`timescale 1ns/10ps

module ecd_edge_clock #(
    parameter int                  NUM_EDGE   = ecd_pkg::NUM_EDGE,
    parameter ecd_pkg::ecd_ratio_t DIV_RATIO  = ecd_pkg::ECD_RATIO_2_0,
    parameter bit                  GSR_ENABLE = 1'b0
) (
    input  wire logic                                  i_clock,
    input  wire logic                                  i_rstn,
    input  wire logic [NUM_EDGE-1:0]                   i_first_clock_input,
    input  wire logic [NUM_EDGE-1:0]                   i_second_clock_input,
    input  wire ecd_pkg::ecd_ctrl_t [NUM_EDGE-1:0]     i_edge_ctrl,
    input  wire logic                                  i_global_set_reset,
    output logic [NUM_EDGE-1:0]                        o_selected_edge_clock_out,
    output logic [NUM_EDGE-1:0]                        o_gate_clock_out,
    output logic [NUM_EDGE-1:0]                        o_undivided_output,
    output logic [NUM_EDGE-1:0]                        o_divided_output
);

    // ********************************
    // Input synchronisers
    // ********************************
    // Sources arrive from pins, so they are sampled and not used as clocks
    logic [NUM_EDGE-1:0]               first_clock_input_s1_r;
    logic [NUM_EDGE-1:0]               first_clock_input_s2_r;
    logic [NUM_EDGE-1:0]               second_clock_input_s1_r;
    logic [NUM_EDGE-1:0]               second_clock_input_s2_r;
    ecd_pkg::ecd_ctrl_t [NUM_EDGE-1:0] ctrl_s1_r;
    ecd_pkg::ecd_ctrl_t [NUM_EDGE-1:0] ctrl_s2_r;
    logic                              gsr_s1_r;
    logic                              gsr_s2_r;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            first_clock_input_s1_r <= '0;
            first_clock_input_s2_r <= '0;
            second_clock_input_s1_r <= '0;
            second_clock_input_s2_r <= '0;
            ctrl_s1_r <= '0;
            ctrl_s2_r <= '0;
            gsr_s1_r  <= 1'b0;
            gsr_s2_r  <= 1'b0;
        end else begin
            first_clock_input_s1_r <= i_first_clock_input;
            first_clock_input_s2_r <= first_clock_input_s1_r;
            second_clock_input_s1_r <= i_second_clock_input;
            second_clock_input_s2_r <= second_clock_input_s1_r;
            ctrl_s1_r <= i_edge_ctrl;
            ctrl_s2_r <= ctrl_s1_r;
            gsr_s1_r  <= i_global_set_reset;
            gsr_s2_r  <= gsr_s1_r;
        end
    end

    // ********************************
    // Bridge select mux and stop gate
    // ********************************
    logic [NUM_EDGE-1:0] mux_r;
    logic [NUM_EDGE-1:0] mux_nxt;
    logic [NUM_EDGE-1:0] stopped_r;
    logic [NUM_EDGE-1:0] stopped_nxt;
    logic [NUM_EDGE-1:0] gate_r;
    logic [NUM_EDGE-1:0] gate_nxt;

    always_comb begin
        for (int e = 0; e < NUM_EDGE; e++) begin
            // No sync between sources: a switch may clip a pulse
            mux_nxt[e]     = ctrl_s2_r[e].select ? second_clock_input_s2_r[e] : first_clock_input_s2_r[e];
            stopped_nxt[e] = stopped_r[e];
            if (!mux_r[e]) begin
                stopped_nxt[e] = ctrl_s2_r[e].stop;
            end
            gate_nxt[e]    = mux_r[e] & ~stopped_r[e];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            mux_r     <= '0;
            stopped_r <= '0;
            gate_r    <= '0;
        end else begin
            mux_r     <= mux_nxt;
            stopped_r <= stopped_nxt;
            gate_r    <= gate_nxt;
        end
    end

    // ********************************
    // Dividers
    // ********************************
    ecd_pkg::ecd_div_out_t [NUM_EDGE-1:0] div_out;

    for (genvar g = 0; g < NUM_EDGE; g++) begin : g_div
        ecd_divider #(
            .DIV_RATIO  (DIV_RATIO),
            .GSR_ENABLE (GSR_ENABLE)
        ) u_edge_clock_divider (
            .i_clock              (i_clock),
            .i_rstn               (i_rstn),
            .i_divider_clock_in   (gate_r[g]),
            .i_div_reset          (ctrl_s2_r[g].div_reset),
            .i_global_set_reset   (gsr_s2_r),
            .i_word_align_request (ctrl_s2_r[g].word_align_request),
            .o_out                (div_out[g])
        );
    end

    // ********************************
    // Outputs
    // ********************************
    always_comb begin
        for (int e = 0; e < NUM_EDGE; e++) begin
            o_undivided_output[e] = div_out[e].undivided_output;
            o_divided_output[e]   = div_out[e].divided_output;
        end
    end

    assign o_selected_edge_clock_out = mux_r;
    assign o_gate_clock_out          = gate_r;

endmodule : ecd_edge_clock

// ### tb/ecd_edge_clock_assertions.sv
`timescale 1ns/10ps

module ecd_edge_clock_assertions #(
    parameter int                  NUM_EDGE   = 4,
    parameter ecd_pkg::ecd_ratio_t DIV_RATIO  = ecd_pkg::ECD_RATIO_2_0,
    parameter bit                  GSR_ENABLE = 1'b0
) (
    input  wire logic                              i_clock,
    input  wire logic                              i_rstn,
    input  wire logic [NUM_EDGE-1:0]               i_first_clock_input,
    input  wire logic [NUM_EDGE-1:0]               i_second_clock_input,
    input  wire ecd_pkg::ecd_ctrl_t [NUM_EDGE-1:0] i_edge_ctrl,
    input  wire logic                              i_global_set_reset,
    input  wire logic [NUM_EDGE-1:0]               o_selected_edge_clock_out,
    input  wire logic [NUM_EDGE-1:0]               o_gate_clock_out,
    input  wire logic [NUM_EDGE-1:0]               o_undivided_output,
    input  wire logic [NUM_EDGE-1:0]               o_divided_output
);
    // ********************************
    // Saturating run-length counters; up_r spans all edges, the rest watch edge 0 only to keep it small
    // ********************************
    logic [NUM_EDGE-1:0] mux_exp;
    logic [4:0]          up_r, up_nxt, run_r, run_nxt, off_r, off_nxt, dr_r, dr_nxt;
    function automatic logic [4:0] sat(input logic c, input logic [4:0] v);
        return !c ? 5'h00 : ((v == 5'h1f) ? v : v + 5'h01);
    endfunction : sat
    always_comb begin
        for (int e = 0; e < NUM_EDGE; e++) begin
            mux_exp[e] = i_edge_ctrl[e].select ? i_second_clock_input[e] : i_first_clock_input[e];
        end
        up_nxt  = sat(1'b1, up_r);
        run_nxt = sat(!i_edge_ctrl[0].stop && !i_edge_ctrl[0].div_reset
                      && !(GSR_ENABLE && i_global_set_reset), run_r);
        off_nxt = sat(i_edge_ctrl[0].stop, off_r);
        dr_nxt  = sat(i_edge_ctrl[0].div_reset || (GSR_ENABLE && i_global_set_reset), dr_r);
    end
    always_ff @(posedge i_clock) begin
        up_r  <= i_rstn ? up_nxt : 5'h00;
        run_r <= i_rstn ? run_nxt : 5'h00;
        off_r <= i_rstn ? off_nxt : 5'h00;
        dr_r  <= i_rstn ? dr_nxt : 5'h00;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_mux_select: assert property (
        up_r > 5'h08 |-> o_selected_edge_clock_out == $past(mux_exp, 3))
        else $error("mux output does not follow selected source");
    a_gate_no_clip: assert property (
        up_r > 5'h08 && $fell(o_gate_clock_out[0])
        |-> !$past(o_selected_edge_clock_out[0]) && $past(o_selected_edge_clock_out[0], 2))
        else $error("gate cut a high phase");
    a_gate_no_runt: assert property (
        up_r > 5'h08 && $rose(o_gate_clock_out[0])
        |-> $past(o_selected_edge_clock_out[0]) && !$past(o_selected_edge_clock_out[0], 2))
        else $error("gate rose inside a high phase");
    a_gate_pass_run: assert property (
        run_r > 5'h14 |-> o_gate_clock_out[0] == $past(o_selected_edge_clock_out[0]))
        else $error("gate not forwarding");
    a_gate_stop_off: assert property (
        off_r > 5'h14 |-> !o_gate_clock_out[0])
        else $error("gate not held off");
    a_undiv_follow: assert property (
        run_r > 5'h05 |-> o_undivided_output[0] == $past(o_gate_clock_out[0]))
        else $error("undivided not following gate");
    a_div_reset_low: assert property (
        dr_r > 5'h04 |-> !o_undivided_output[0] && !o_divided_output[0])
        else $error("divider outputs not low in reset");
    a_div_on_edge: assert property (
        run_r > 5'h05 && $changed(o_divided_output[0])
        |-> $past(o_gate_clock_out[0]) != $past(o_gate_clock_out[0], 2))
        else $error("divided toggled off an input edge");
    c_stop: cover property (off_r == 5'h15);
    c_div: cover property ($rose(o_divided_output[0]));
    c_reset: cover property (dr_r == 5'h05);
endmodule : ecd_edge_clock_assertions

bind ecd_edge_clock ecd_edge_clock_assertions #(.NUM_EDGE(NUM_EDGE), .DIV_RATIO(DIV_RATIO),
    .GSR_ENABLE(GSR_ENABLE)) u_chk (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_first_clock_input(i_first_clock_input), .i_second_clock_input(i_second_clock_input),
    .i_edge_ctrl(i_edge_ctrl), .i_global_set_reset(i_global_set_reset),
    .o_selected_edge_clock_out(o_selected_edge_clock_out), .o_gate_clock_out(o_gate_clock_out),
    .o_undivided_output(o_undivided_output), .o_divided_output(o_divided_output));

// ### tb/ecd_core_model.sv
`timescale 1ns/10ps

// ********************************
// Core-side clock sources: periods 16 and 24 cycles, slow enough to sample
// ********************************
module ecd_core_model (
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    output logic      [3:0] o_first_clock_input,
    output logic      [3:0] o_second_clock_input
);
    logic [5:0] cnt_r, cnt_nxt;
    always_comb cnt_nxt = (cnt_r == 6'h2f) ? 6'h00 : cnt_r + 6'h01;
    always_ff @(posedge i_clock) cnt_r <= i_rstn ? cnt_nxt : 6'h00;
    assign o_first_clock_input  = {4{cnt_r[3]}};
    assign o_second_clock_input = {4{(cnt_r >= 6'h0c && cnt_r < 6'h18) || cnt_r >= 6'h24}};
    // Only one bridge mux pair in use per edge; word align kept at 0 by the bench
endmodule : ecd_core_model

// ### tb/ecd_edge_clock_bench.sv
`timescale 1ns/10ps

module ecd_edge_clock_bench;
    // ********************************
    // Stimulus, rise counting and verdict
    // ********************************
    logic                          i_clock = 1'b0;
    logic                          rstn;
    logic                    [3:0] src0, src1, o_s, o_g, o_u, o_d, o_d2, o_d4, sel;
    logic                          global_set_reset_option;
    ecd_pkg::ecd_ctrl_t      [3:0] ctrl;
    logic                   [23:0] obs, p;
    logic                    [7:0] r [24];
    int                            failures, n_tests, cycles;
    always #50 i_clock = ~i_clock;
    assign obs = {o_d4, o_d2, o_d, o_u, o_g, o_s};
    ecd_core_model u_core (.i_clock(i_clock), .i_rstn(rstn), .o_first_clock_input(src0),
        .o_second_clock_input(src1));
    ecd_edge_clock #(.DIV_RATIO(ecd_pkg::ECD_RATIO_3_5)) u_dut (.i_clock(i_clock),
        .i_rstn(rstn), .i_first_clock_input(src0), .i_second_clock_input(src1),
        .i_edge_ctrl(ctrl), .i_global_set_reset(global_set_reset_option), .o_selected_edge_clock_out(o_s),
        .o_gate_clock_out(o_g), .o_undivided_output(o_u), .o_divided_output(o_d));
    // Other ratios; the ratio 2.0 copy also has the global set/reset link on
    ecd_edge_clock #(.DIV_RATIO(ecd_pkg::ECD_RATIO_2_0), .GSR_ENABLE(1'b1)) u_dut_div2 (
        .i_clock(i_clock), .i_rstn(rstn), .i_first_clock_input(src0),
        .i_second_clock_input(src1), .i_edge_ctrl(ctrl), .i_global_set_reset(global_set_reset_option),
        .o_selected_edge_clock_out(), .o_gate_clock_out(), .o_undivided_output(),
        .o_divided_output(o_d2));
    ecd_edge_clock #(.DIV_RATIO(ecd_pkg::ECD_RATIO_4_0)) u_dut_div4 (
        .i_clock(i_clock), .i_rstn(rstn), .i_first_clock_input(src0),
        .i_second_clock_input(src1), .i_edge_ctrl(ctrl), .i_global_set_reset(global_set_reset_option),
        .o_selected_edge_clock_out(), .o_gate_clock_out(), .o_undivided_output(),
        .o_divided_output(o_d4));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    // Settle 24 cycles: sync latency plus a deferred stop on a long high phase
    task automatic set(input logic [3:0] s, input logic [3:0] stp, input logic [3:0] drs);
        @(posedge i_clock);
        sel = s;
        for (int e = 0; e < 4; e++) ctrl[e] <= {s[e], stp[e], drs[e], 1'b0};
        repeat (24) @(posedge i_clock);
    endtask : set
    task automatic measure(input int n);
        foreach (r[i]) r[i] = 8'h00;
        @(negedge i_clock);
        p = obs;
        repeat (n) begin
            @(negedge i_clock);
            foreach (r[i]) r[i] += 8'(obs[i] & !p[i]);
            p = obs;
        end
    endtask : measure
    task automatic end_of_test;
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        ctrl = '0;
        global_set_reset_option = 1'b0;
        rstn = 1'b0;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge i_clock);
        rstn <= 1'b1;
        @(negedge i_clock);
        chk(obs[15:0], 16'h0000);
        chk({8'h00, obs[23:16]}, 16'h0000);
        set(4'b1010, 4'h0, 4'h0);
        measure(96);
        for (int e = 0; e < 4; e++) begin
            chk(r[e], sel[e] ? 16'h4 : 16'h6);
            chk(r[8+e], sel[e] ? 16'h4 : 16'h6);
        end
        set(4'b0101, 4'b0001, 4'h0);
        measure(96);
        for (int e = 0; e < 4; e++) begin
            chk(r[e], sel[e] ? 16'h4 : 16'h6);
            chk(r[4+e], (e == 0) ? 16'h0 : (sel[e] ? 16'h4 : 16'h6));
        end
        set(4'h0, 4'h0, 4'h0);
        measure(112);
        for (int e = 0; e < 4; e++) begin
            chk(r[8+e], 16'h7);
            chk(r[12+e], 16'h2);
        end
        measure(64);
        for (int e = 0; e < 4; e++) begin
            chk(r[16+e], 16'h2);
            chk(r[20+e], 16'h1);
        end
        @(posedge i_clock);
        global_set_reset_option <= 1'b1;
        set(4'h0, 4'h0, 4'b0001);
        measure(48);
        chk(r[8], 16'h0);
        chk({r[12], r[9]}, 16'h0003);
        chk({obs[12], obs[8]}, 16'h0);
        for (int e = 0; e < 4; e++) chk(r[16+e], 16'h0);
        chk({12'h000, obs[19:16]}, 16'h0000);
        end_of_test();
    end
endmodule : ecd_edge_clock_bench
